// ===== verilog/alarm_detector.sv
// Receive alarm detector: yellow, red and ALL_ONES_ALARM_STATE with change flags
//
// Contract
// RULE1: Japan variant bit picks T1 (0) or J1 (1) yellow rules.
// RULE2: Format bit picks SF (0) or ESF (1) detection rules.
// RULE3: Red clears after 16.6 s, ALL_ONES_ALARM_STATE after 16.8 s; fast: 120/180 ms.
// RULE4: Interrupt output low while an enabled change flag is set.
// RULE5: Change flag sets when its alarm state toggles either way.
// RULE6: Reading interrupt status clears all change flags.
// RULE7: Yellow state follows yellow indication after 425 ms either way.
// RULE8: Red sets after sync-loss indicator holds 1 for 2.55 s.
// RULE9: ALL_ONES_ALARM_STATE sets after ALL_ONES_ALARM_STATE indication holds 1 for 1.5 s.
// RULE10: Sync-loss indicator is 1 if sync was lost in the last 40 ms.
// RULE11: Yellow window 40 ms; ESF fast 20 ms; ESF absence after 4 ms.
// RULE12: T1 SF yellow when channel bit 2 was 1 at most 16 times.
// RULE13: J1 SF yellow when frame-12 F-bit was 0 at most 2 times.
// RULE14: ESF yellow pattern on data link is FF00 (T1) or FFFF (J1).
// RULE15: ESF yellow accepted on 8 of 10 codes, or 4 of 5 codes.
// RULE16: ALL_ONES_ALARM_STATE indication when out of sync all 60 ms with <127 zeros.
// RULE17: Validation bit selects 8-of-10 or 4-of-5 code acceptance.
// RULE18: All windows and timers run from a millisecond tick.
`timescale 1ns/100ps
module alarm_detector #(
  parameter int MS_CYCLES = alarm_detector_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  // Receive framer stream
  input  wire logic       rx_bit_en,
  input  wire logic       rx_bit,
  input  wire logic       rx_chan_bit2,
  input  wire logic       rx_frame12_fbit,
  input  wire logic       rx_dl_en,
  input  wire logic       rx_dl_bit,
  input  wire logic       rx_in_frame,
  // Interrupt
  output logic            irq_n
);
  import alarm_detector_pkg::*;

  // ==========================================================
  // Elaboration check
  if (MS_CYCLES < 16 || MS_CYCLES > 65535) begin : g_bad_ms
    $error("MS_CYCLES must lie in 16..65535");
  end

  localparam logic [15:0] TICK_LAST = 16'(MS_CYCLES - 1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] tick_cnt;
    logic        tick;
    logic        japan;
    logic        esf;
    logic        fast;
    logic        code_validation_select;
    logic [2:0]  ien;
    logic [2:0]  chg;
    logic        remote_alarm_state;
    logic        loss_frame_alarm_state;
    logic        all_ones_alarm_state;
    logic        remote_indication_seen;
    logic        sync_loss_seen;
    logic        all_ones_seen;
    logic [5:0]  red_win;
    logic        red_acc;
    logic [5:0]  ais_win;
    logic        ais_oof_all;
    logic [6:0]  zero_cnt;
    logic [5:0]  yel_win;
    logic [4:0]  sf_cnt;
    logic        esf_seen;
    logic [2:0]  esf_idle;
    logic [15:0] dl_sh;
    logic [3:0]  dl_bits;
    logic [9:0]  match_hist;
    logic        esf_ack;
    logic [14:0] yel_cnt;
    logic [14:0] red_cnt;
    logic [14:0] ais_cnt;
    logic [7:0]  rdata;
    logic        irq_n;
  } state_s;

  localparam state_s STATE_RST = '{irq_n: 1'b1, default: '0};

  state_s s;
  state_s n;

  // ==========================================================
  // Functions
  function automatic logic [3:0] ones(input logic [9:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 10; i++) begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction : ones

  // Returns {state, count}; count runs while input differs from state
  function automatic logic [15:0] persist_step(
    input logic        st,
    input logic        din,
    input logic        tick,
    input logic [14:0] cnt,
    input logic [14:0] lim
  );
    logic        ns;
    logic [14:0] nc;
    ns = st;
    nc = cnt;
    if (din == st) begin
      nc = 15'h0;
    end else if (tick) begin
      if (cnt >= lim - 15'h1) begin
        ns = din;
        nc = 15'h0;
      end else begin
        nc = cnt + 15'h1;
      end
    end
    return {ns, nc};
  endfunction : persist_step

  // ==========================================================
  // Next state
  logic        oof;
  logic        sf_evt;
  logic [5:0]  yel_len;
  logic [15:0] code;
  logic [15:0] pat;
  logic [9:0]  hist;
  logic [6:0]  zeros_now;
  logic [4:0]  sf_now;
  logic [14:0] red_lim;
  logic [14:0] ais_lim;
  logic        ist_read;

  always_comb begin
    n         = s;
    oof       = ~rx_in_frame;
    ist_read  = rd_en && (addr == OFS_IST);
    code      = {s.dl_sh[14:0], rx_dl_bit};
    pat       = s.japan ? ESF_YEL_J1 : ESF_YEL_T1;               // RULE14
    hist      = {s.match_hist[8:0], code == pat};
    zeros_now = s.zero_cnt;
    sf_now    = s.sf_cnt;
    red_lim   = s.loss_frame_alarm_state ? (s.fast ? RED_CLR_FAST_MS : RED_CLR_SLOW_MS)
                      : RED_SET_MS;                             // RULE3
    ais_lim   = s.all_ones_alarm_state ? (s.fast ? AIS_CLR_FAST_MS : AIS_CLR_SLOW_MS)
                      : AIS_SET_MS;                             // RULE3
    yel_len   = (s.esf && s.code_validation_select) ? WIN_YEL_FAST_MS : WIN_YEL_MS; // RULE11

    // Millisecond tick
    n.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST) begin                          // RULE18
      n.tick_cnt = 16'h0;
      n.tick     = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 16'h1;
    end

    // Register writes
    if (wr_en) begin
      if (addr == OFS_CFG) begin
        n.japan = wr_data[CFG_JAPAN_BIT];                       // RULE1
        n.esf   = wr_data[CFG_ESF_BIT];                         // RULE2
      end else if (addr == OFS_IEN) begin
        n.fast  = wr_data[IEN_FAST_BIT];
        n.ien   = {wr_data[IEN_YEL_BIT], wr_data[IEN_RED_BIT],
                   wr_data[IEN_AIS_BIT]};
      end else if (addr == OFS_VALID) begin
        n.code_validation_select   = wr_data[VALID_AVC_BIT];                       // RULE17
      end
    end

    // Sync-loss window
    if (oof) begin
      n.red_acc = 1'b1;
    end
    if (s.tick) begin
      if (s.red_win == WIN_RED_MS - 6'h1) begin
        n.sync_loss_seen    = s.red_acc | oof;                            // RULE10
        n.red_acc = 1'b0;
        n.red_win = 6'h0;
      end else begin
        n.red_win = s.red_win + 6'h1;
      end
    end

    // ALL_ONES_ALARM_STATE window
    if (rx_bit_en && !rx_bit && s.zero_cnt != AIS_ZERO_LIMIT) begin
      zeros_now = s.zero_cnt + 7'h1;
    end
    n.zero_cnt    = zeros_now;
    n.ais_oof_all = s.ais_oof_all & oof;
    if (s.tick) begin
      if (s.ais_win == WIN_AIS_MS - 6'h1) begin
        n.all_ones_seen        = s.ais_oof_all & oof &
                        (zeros_now < AIS_ZERO_LIMIT);           // RULE16
        n.ais_oof_all = 1'b1;
        n.zero_cnt    = 7'h0;
        n.ais_win     = 6'h0;
      end else begin
        n.ais_win = s.ais_win + 6'h1;
      end
    end

    // SF yellow counting
    sf_evt = s.japan ? (rx_bit_en & rx_frame12_fbit & ~rx_bit)  // RULE13
                     : (rx_bit_en & rx_chan_bit2 & rx_bit);     // RULE12
    if (sf_evt && s.sf_cnt != 5'h1f) begin
      sf_now = s.sf_cnt + 5'h1;
    end
    n.sf_cnt = sf_now;

    // ESF data-link code check
    if (rx_dl_en) begin
      n.dl_sh = code;
      if (s.dl_bits == 4'hf) begin
        n.dl_bits    = 4'h0;
        n.match_hist = hist;
        n.esf_ack    = s.code_validation_select ? (ones({5'h0, hist[4:0]}) >= ACK_OF5)
                             : (ones(hist) >= ACK_OF10);        // RULE15
      end else begin
        n.dl_bits = s.dl_bits + 4'h1;
      end
    end
    if (n.esf_ack) begin
      n.esf_seen = 1'b1;
      n.esf_idle = 3'h0;
    end else if (s.tick && s.esf_idle != ESF_ABSENT_MS) begin
      n.esf_idle = s.esf_idle + 3'h1;
    end
    if (s.esf && n.esf_idle == ESF_ABSENT_MS) begin
      n.remote_indication_seen = 1'b0;                                            // RULE11
    end

    // Yellow window
    if (s.tick) begin
      if (s.yel_win >= yel_len - 6'h1) begin
        if (!s.esf) begin                                       // RULE2
          n.remote_indication_seen = s.japan ? (sf_now <= SF_J1_MAX_ZEROS)        // RULE13
                           : (sf_now <= SF_T1_MAX_ONES);        // RULE12
        end else if (n.esf_seen) begin
          n.remote_indication_seen = 1'b1;                                        // RULE11
        end
        n.sf_cnt   = 5'h0;
        n.esf_seen = n.esf_ack;
        n.yel_win  = 6'h0;
      end else begin
        n.yel_win = s.yel_win + 6'h1;
      end
    end

    // Persistence
    {n.remote_alarm_state, n.yel_cnt} = persist_step(s.remote_alarm_state, s.remote_indication_seen, s.tick,
                                      s.yel_cnt, YEL_PERSIST_MS); // RULE7
    {n.loss_frame_alarm_state, n.red_cnt} = persist_step(s.loss_frame_alarm_state, s.sync_loss_seen, s.tick,
                                      s.red_cnt, red_lim);        // RULE8
    {n.all_ones_alarm_state, n.ais_cnt} = persist_step(s.all_ones_alarm_state, s.all_ones_seen, s.tick,
                                      s.ais_cnt, ais_lim);        // RULE9

    // Change flags: a toggle in the read cycle survives the clear
    n.chg = (ist_read ? 3'h0 : s.chg) |                         // RULE6
            {n.remote_alarm_state ^ s.remote_alarm_state, n.loss_frame_alarm_state ^ s.loss_frame_alarm_state, n.all_ones_alarm_state ^ s.all_ones_alarm_state};      // RULE5
    n.irq_n = ~|(n.chg & n.ien);                                // RULE4

    // Read data, valid one cycle after the strobe
    n.rdata = 8'h00;
    if (rd_en) begin
      if (addr == OFS_CFG) begin
        n.rdata[CFG_JAPAN_BIT] = s.japan;
        n.rdata[CFG_ESF_BIT]   = s.esf;
      end else if (addr == OFS_IEN) begin
        n.rdata[IEN_FAST_BIT] = s.fast;
        n.rdata[IEN_YEL_BIT]  = s.ien[2];
        n.rdata[IEN_RED_BIT]  = s.ien[1];
        n.rdata[IEN_AIS_BIT]  = s.ien[0];
      end else if (addr == OFS_IST) begin
        n.rdata[IST_CHG_LSB +: 3] = s.chg;
        n.rdata[IST_YEL_BIT]      = s.remote_alarm_state;
        n.rdata[IST_RED_BIT]      = s.loss_frame_alarm_state;
        n.rdata[IST_AIS_BIT]      = s.all_ones_alarm_state;
      end else if (addr == OFS_DET) begin
        n.rdata[DET_SYNC_LOSS_SEEN_BIT] = s.sync_loss_seen;
        n.rdata[DET_REMOTE_INDICATION_SEEN_BIT] = s.remote_indication_seen;
        n.rdata[DET_ALL_ONES_SEEN_BIT] = s.all_ones_seen;
      end else if (addr == OFS_VALID) begin
        n.rdata[VALID_AVC_BIT] = s.code_validation_select;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign rd_data = s.rdata;
  assign irq_n   = s.irq_n;

  // ==========================================================
  // Assertions
  irq_level_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE4
    irq_n == !(|(s.chg & s.ien)))
    else $error("interrupt output disagrees with enabled flags");

  change_set_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE5
    ($changed(s.remote_alarm_state) |-> s.chg[2]) and ($changed(s.loss_frame_alarm_state) |-> s.chg[1])
    and ($changed(s.all_ones_alarm_state) |-> s.chg[0]))
    else $error("alarm toggled without change flag");

  read_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
    rd_en && addr == OFS_IST |=>
    s.chg == {$changed(s.remote_alarm_state), $changed(s.loss_frame_alarm_state), $changed(s.all_ones_alarm_state)})
    else $error("status read did not clear change flags");

  yel_persist_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE7
    $changed(s.remote_alarm_state) |->
    $past(s.yel_cnt) == YEL_PERSIST_MS - 15'h1 && $past(s.tick))
    else $error("yellow state changed before 425 ms");

  red_set_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE8
    $rose(s.loss_frame_alarm_state) |-> $past(s.sync_loss_seen) && $past(s.red_cnt) == RED_SET_MS - 15'h1)
    else $error("red set without 2.55 s of sync loss");

  red_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE3
    $fell(s.loss_frame_alarm_state) |-> $past(s.red_cnt) ==
    ($past(s.fast) ? RED_CLR_FAST_MS : RED_CLR_SLOW_MS) - 15'h1)
    else $error("red cleared after wrong hold time");

  ais_set_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE9
    $rose(s.all_ones_alarm_state) |-> $past(s.all_ones_seen) && $past(s.ais_cnt) == AIS_SET_MS - 15'h1)
    else $error("ALL_ONES_ALARM_STATE set without 1.5 s of indication");

  tick_gap_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE18
    s.tick |=> !s.tick [*8])
    else $error("millisecond tick repeated too soon");

  sync_loss_seen_window_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE10
    $changed(s.sync_loss_seen) |-> $past(s.tick) && s.red_win == 6'h0)
    else $error("sync-loss indicator moved off window end");

  ais_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE3
    $fell(s.all_ones_alarm_state) |-> $past(s.ais_cnt) ==
    ($past(s.fast) ? AIS_CLR_FAST_MS : AIS_CLR_SLOW_MS) - 15'h1)
    else $error("ALL_ONES_ALARM_STATE cleared after wrong hold time");

  all_ones_seen_window_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE16
    $changed(s.all_ones_seen) |-> $past(s.tick) && s.ais_win == 6'h0)
    else $error("ALL_ONES_ALARM_STATE indicator moved off window end");

  chg_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
    !(rd_en && addr == OFS_IST) && s.chg[2] |=> s.chg[2])
    else $error("remote change flag lost without a status read");

endmodule : alarm_detector

// ===== shared/alarm_detector_pkg.sv
// Constants for the receive alarm detector
package alarm_detector_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_VALID   = 8'h2a;
  localparam logic [7:0] OFS_CFG     = 8'h2c;
  localparam logic [7:0] OFS_IEN     = 8'h2d;
  localparam logic [7:0] OFS_IST     = 8'h2e;
  localparam logic [7:0] OFS_DET     = 8'h2f;

  // ==========================================================
  // Field positions
  localparam int VALID_AVC_BIT  = 1;
  localparam int CFG_JAPAN_BIT  = 5;
  localparam int CFG_ESF_BIT    = 4;
  localparam int IEN_FAST_BIT   = 4;
  localparam int IEN_YEL_BIT    = 2;
  localparam int IEN_RED_BIT    = 1;
  localparam int IEN_AIS_BIT    = 0;
  localparam int IST_CHG_LSB    = 3;
  localparam int IST_YEL_BIT    = 2;
  localparam int IST_RED_BIT    = 1;
  localparam int IST_AIS_BIT    = 0;
  localparam int DET_SYNC_LOSS_SEEN_BIT   = 2;
  localparam int DET_REMOTE_INDICATION_SEEN_BIT   = 1;
  localparam int DET_ALL_ONES_SEEN_BIT   = 0;

  // ==========================================================
  // Reset values of control fields
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] IEN_RST   = 8'h00;
  localparam logic       AVC_RST   = 1'b0;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_TICK_NS    = 1000000;
  localparam int CYC_PER_MS    = MS_TICK_NS / CLK_PERIOD_NS;

  localparam logic [14:0] YEL_PERSIST_MS  = 15'd425;
  localparam logic [14:0] RED_SET_MS      = 15'd2550;
  localparam logic [14:0] RED_CLR_SLOW_MS = 15'd16600;
  localparam logic [14:0] RED_CLR_FAST_MS = 15'd120;
  localparam logic [14:0] AIS_SET_MS      = 15'd1500;
  localparam logic [14:0] AIS_CLR_SLOW_MS = 15'd16800;
  localparam logic [14:0] AIS_CLR_FAST_MS = 15'd180;
  localparam logic [5:0]  WIN_RED_MS      = 6'd40;
  localparam logic [5:0]  WIN_AIS_MS      = 6'd60;
  localparam logic [5:0]  WIN_YEL_MS      = 6'd40;
  localparam logic [5:0]  WIN_YEL_FAST_MS = 6'd20;
  localparam logic [2:0]  ESF_ABSENT_MS   = 3'd4;

  // ==========================================================
  // Detection thresholds and patterns
  localparam logic [4:0]  SF_T1_MAX_ONES  = 5'd16;
  localparam logic [4:0]  SF_J1_MAX_ZEROS = 5'd2;
  localparam logic [6:0]  AIS_ZERO_LIMIT  = 7'd127;
  localparam logic [15:0] ESF_YEL_T1      = 16'hff00;
  localparam logic [15:0] ESF_YEL_J1      = 16'hffff;
  localparam logic [3:0]  ACK_OF10        = 4'd8;
  localparam logic [3:0]  ACK_OF5         = 4'd4;

endpackage : alarm_detector_pkg

// ===== dv/framer_model.sv
// Receive framer model that feeds line bits and sync state
`timescale 1ns/100ps
module framer_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Scenario control
  input  wire logic sync_ok,
  input  wire logic yel_on,
  // Line stream
  output logic      rx_bit_en,
  output logic      rx_bit,
  output logic      rx_chan_bit2,
  output logic      rx_frame12_fbit,
  output logic      rx_dl_en,
  output logic      rx_dl_bit,
  output logic      rx_in_frame
);
  logic [3:0]  dl_idx;
  logic [15:0] dl_pat;

  // Data-link code, sent first bit first; remote alarm sends ff00
  assign dl_pat = yel_on ? 16'hff00 : 16'h0000;

  // =======================================================
  // One channel bit 2 per cycle; ones mean no remote alarm
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dl_idx          <= 4'h0;
      rx_bit_en       <= 1'b0;
      rx_bit          <= 1'b1;
      rx_chan_bit2    <= 1'b0;
      rx_frame12_fbit <= 1'b0;
      rx_dl_en        <= 1'b0;
      rx_dl_bit       <= 1'b0;
      rx_in_frame     <= 1'b0;
    end else begin
      rx_bit_en       <= 1'b1;
      rx_bit          <= ~yel_on;
      rx_chan_bit2    <= 1'b1;
      rx_frame12_fbit <= 1'b0;
      rx_dl_en        <= ~rx_dl_en;
      if (!rx_dl_en) begin
        rx_dl_bit <= dl_pat[4'hf - dl_idx];
        dl_idx    <= dl_idx + 4'h1;
      end
      rx_in_frame     <= sync_ok;
    end
  end
endmodule : framer_model

// ===== dv/alarm_detector_test.sv
// Register level test of the receive alarm detector
`timescale 1ns/100ps
module alarm_detector_test;
  import alarm_detector_pkg::*;
  localparam int MS = 16;
  localparam int LIMIT = 90000;
  logic ref_clk = 1'b0, reset = 1'b1;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data;
  logic wr_en = 1'b0, rd_en = 1'b0, irq_n;
  logic sync_ok = 1'b0, yel_on = 1'b0;
  logic rx_bit_en, rx_bit, rx_chan_bit2, rx_frame12_fbit;
  logic rx_dl_en, rx_dl_bit, rx_in_frame;
  int failures = 0, num_checks = 0, cyc = 0, t0 = 0;

  alarm_detector #(.MS_CYCLES(MS)) i_alarm_detector (
    .ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .rx_chan_bit2(rx_chan_bit2),
    .rx_frame12_fbit(rx_frame12_fbit), .rx_dl_en(rx_dl_en),
    .rx_dl_bit(rx_dl_bit), .rx_in_frame(rx_in_frame), .irq_n(irq_n));

  framer_model i_framer_model (
    .ref_clk(ref_clk), .reset(reset), .sync_ok(sync_ok), .yel_on(yel_on),
    .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .rx_chan_bit2(rx_chan_bit2),
    .rx_frame12_fbit(rx_frame12_fbit), .rx_dl_en(rx_dl_en),
    .rx_dl_bit(rx_dl_bit), .rx_in_frame(rx_in_frame));

  // =======================================================
  // Clock, cycle count and hang guard
  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures = failures + 1;
      final_report();
    end
  end

  // =======================================================
  // Checks and bus cycles
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), exp, rd_data);
  endtask : rd

  // Waits for irq_n low, returns cycles since t0 or -1
  task automatic wait_irq(input int max, output int dt);
    int n;
    n = 0;
    dt = -1;
    while (n < max && irq_n !== 1'b0) begin
      @(posedge ref_clk);
      #1;
      n = n + 1;
    end
    if (irq_n === 1'b0) dt = cyc - t0;
  endtask : wait_irq

  task automatic in_range(input string name, input int dt,
                          input int lo, input int hi);
    chk(name, 1, (dt >= lo && dt <= hi));
  endtask : in_range

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // =======================================================
  // Test sequence
  initial begin : main
    int dt;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t0 = 0;
    rd(OFS_CFG, CFG_RST);
    rd(OFS_IEN, IEN_RST);
    rd(OFS_IST, 8'h00);
    rd(8'h30, 8'h00);
    wr(OFS_CFG, 8'hff);
    rd(OFS_CFG, 8'h30);
    wr(OFS_CFG, 8'h00);
    wr(OFS_IEN, 8'hff);
    rd(OFS_IEN, 8'h17);
    wr(OFS_VALID, 8'hff);
    rd(OFS_VALID, 8'h02);
    wr(OFS_VALID, 8'h00);
    wr(OFS_DET, 8'hff);
    rd(OFS_DET, 8'h00);
    $display("test registers done");

    wr(OFS_IEN, 8'h13);
    t0 = cyc;
    wait_irq(1700 * MS, dt);
    in_range("ais set time", dt, 1500 * MS, 1625 * MS);
    rd(OFS_DET, 8'h05);
    rd(OFS_IST, 8'h09);
    #1;
    chk("irq after read", 1'b1, irq_n);
    wait_irq(1200 * MS, dt);
    in_range("red set time", dt, 2550 * MS, 2600 * MS);
    rd(OFS_IST, 8'h13);
    rd(OFS_IST, 8'h03);
    $display("test alarm set done");

    sync_ok <= 1'b1;
    repeat (300 * MS) @(posedge ref_clk);
    #1;
    chk("irq on clear", 1'b0, irq_n);
    rd(OFS_DET, 8'h00);
    rd(OFS_IST, 8'h18);
    $display("test fast clear done");

    wr(OFS_IEN, 8'h10);
    yel_on <= 1'b1;
    repeat (600 * MS) @(posedge ref_clk);
    #1;
    chk("irq masked", 1'b1, irq_n);
    rd(OFS_DET, 8'h02);
    rd(OFS_IST, 8'h24);
    wr(OFS_IEN, 8'h14);
    #1;
    chk("irq idle", 1'b1, irq_n);
    yel_on <= 1'b0;
    t0 = cyc;
    wait_irq(700 * MS, dt);
    in_range("yel clear time", dt, 425 * MS, 507 * MS);
    rd(OFS_IST, 8'h20);
    $display("test remote alarm done");

    wr(OFS_CFG, 8'h10);
    yel_on <= 1'b1;
    repeat (80 * MS) @(posedge ref_clk);
    rd(OFS_DET, 8'h02);
    yel_on <= 1'b0;
    repeat (20 * MS) @(posedge ref_clk);
    rd(OFS_DET, 8'h00);
    wr(OFS_CFG, 8'h30);
    wr(OFS_VALID, 8'h02);
    yel_on <= 1'b1;
    repeat (60 * MS) @(posedge ref_clk);
    rd(OFS_DET, 8'h00);
    $display("test esf remote alarm done");
    final_report();
  end
endmodule : alarm_detector_test
